// >>> capture_pkg.sv
// constants shared by the header and sub-code capture block
package capture_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] HDR_MODE_IDX  = 16'hf092;
  localparam logic [15:0] HDR_MIN_IDX   = 16'hf093;
  localparam logic [15:0] HDR_SEC_IDX   = 16'hf09a;
  localparam logic [15:0] HDR_FRM_IDX   = 16'hf09b;
  localparam logic [15:0] Q_TRACK_IDX   = 16'hf0a9;
  localparam logic [15:0] Q_MODE_IDX    = 16'hf0aa;
  localparam logic [15:0] Q_AMIN_IDX    = 16'hf0ab;
  localparam logic [15:0] Q_ASEC_IDX    = 16'hf0b1;
  localparam logic [15:0] Q_AFRM_IDX    = 16'hf0b2;
  localparam logic [15:0] FRONT_CTRL_IDX = 16'hf0bb;
  localparam logic [15:0] READ_STAT_IDX = 16'hf0c3;
  localparam int unsigned ADDR_W = 18;

  // front-end control fields
  localparam int unsigned FC_SEQ_RESET = 7;
  localparam int unsigned FC_RESYNC    = 6;
  localparam int unsigned FC_TX_BREAK  = 5;
  localparam int unsigned FC_WDOG_DIS  = 4;
  localparam int unsigned FC_REDBOOK   = 3;
  localparam int unsigned FC_AUDIO     = 2;
  localparam int unsigned FC_SYNC_SEL  = 1;
  localparam int unsigned FC_STOP      = 0;
  localparam logic [7:0]  FRONT_CTRL_RESET = 8'h01;

  // read status fields
  localparam int unsigned RS_CLK_RUN   = 7;
  localparam int unsigned RS_BAD_Q     = 6;
  localparam int unsigned RS_Q_READY   = 5;
  localparam int unsigned RS_HDR_VALID = 4;

  // q frame layout, byte numbers counted from the first byte
  localparam int unsigned Q_BITS      = 96;
  localparam int unsigned Q_DATA_BITS = 80;
  localparam int unsigned Q_BYTE_MODE = 0;
  localparam int unsigned Q_BYTE_TRK  = 1;
  localparam int unsigned Q_BYTE_AMIN = 7;
  localparam int unsigned Q_BYTE_ASEC = 8;
  localparam int unsigned Q_BYTE_AFRM = 9;
  localparam logic [15:0] Q_CRC_POLY  = 16'h1021;
  localparam logic [15:0] Q_CRC_INIT  = 16'h0000;

  // header byte order after the sync pattern
  localparam logic [1:0] HB_MIN  = 2'h0;
  localparam logic [1:0] HB_SEC  = 2'h1;
  localparam logic [1:0] HB_FRM  = 2'h2;
  localparam logic [1:0] HB_MODE = 2'h3;

  // header sequencer states, gray along idle-header-body
  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_HEADER = 2'b01,
    HS_BODY   = 2'b11
  } hdr_state_t;
endpackage : capture_pkg

// >>> cd_header_subcode_capture.sv
// sector header and q sub-channel capture with apb register access
// What this block does
// - in data mode latch header mode, minute, second, frame into read-only bytes
// - header bytes valid only while header-valid flag set; firmware checks it
// - in audio mode minute/second/frame come from the q sub-channel
// - load track, mode, absolute msf from raw sub-channel into read-only bytes
// - assemble twelve q bytes per frame; last two are crc parity
// - q validity produced only after last bit shifted and crc checked
// - set q-frame-ready in read status when a q frame is captured
// - bad-q reads low when crc passes, high when it fails
// - with data clock running, bad-q holds until the end of the sector
// - with data clock stopped, bad-q holds until the end of next q frame
// - front-end control bit layout: reset, resync, break, watchdog, redbook, audio, sync, stop
// - stop command starts flow at the next sync, stops it there with sync select set, at once without; set on reset
// - audio mode: redbook enable starts or stops flow at next f1 c-flag
// - audio select low means data mode, the reset value
// - resync high-then-low starts sync search; header valid once the four header bytes after a sync are taken
//
// Design decision made here: the APB register port.
module cd_header_subcode_capture
  import capture_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [capture_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [7:0]                  data_byte,
  input  wire logic                        data_byte_valid,
  input  wire logic                        sync_found,
  input  wire logic                        sector_end,
  input  wire logic                        f1_cflag,
  input  wire logic                        q_bit,
  input  wire logic                        q_bit_valid,
  input  wire logic                        q_frame_start,
  output logic                             store_enable,
  output logic                             sync_search,
  output logic                             tx_break,
  output logic                             watchdog_off,
  output logic                             seq_reset,
  output logic                             audio_clock_shift
);
  import capture_pkg::*;

  // crc-16 one bit at a time, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic bit_in);
    logic fb;
    fb = crc[15] ^ bit_in;
    crc_step = {crc[14:0], 1'b0} ^ (fb ? Q_CRC_POLY : 16'h0000);
  endfunction : crc_step

  logic [7:0]  front_ctrl_reg_q;
  logic [7:0]  hdr_mode_q, hdr_minute_reg_q, hdr_second_reg_q, hdr_frame_reg_q;
  logic [7:0]  q_track_reg_q, q_mode_reg_q, q_abs_minute_reg_q;
  logic [7:0]  q_abs_second_reg_q, q_abs_frame_reg_q;
  logic        header_valid_flag_q, q_frame_ready_q, q_crc_fail_flag_q;
  logic        resync_prev_q, search_q, flow_q;
  hdr_state_t  hdr_state_q;
  logic [1:0]  hdr_cnt_q;
  logic [6:0]  q_cnt_q;
  logic [Q_DATA_BITS-1:0] q_shift_q;
  logic [15:0] q_crc_q;
  logic        q_mismatch_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  // control field views
  wire stop_command      = front_ctrl_reg_q[FC_STOP];
  wire sync_async_select = front_ctrl_reg_q[FC_SYNC_SEL];
  wire audio_mode_select = front_ctrl_reg_q[FC_AUDIO];
  wire redbook_enable    = front_ctrl_reg_q[FC_REDBOOK];
  wire watchdog_disable  = front_ctrl_reg_q[FC_WDOG_DIS];
  wire resync_pulse      = front_ctrl_reg_q[FC_RESYNC];
  wire frame_seq_reset   = front_ctrl_reg_q[FC_SEQ_RESET];
  wire data_clock_run    = audio_mode_select ? redbook_enable : ~stop_command;

  // apb decode; the word index sits above the two byte-lane bits
  wire [15:0] word_idx   = paddr[ADDR_W-1:2];
  wire        setup_ph   = psel & ~penable;
  wire        access_ph  = psel & penable;
  wire        sel_ctrl   = (word_idx == FRONT_CTRL_IDX);
  wire        sel_stat   = (word_idx == READ_STAT_IDX);
  wire        sel_ro     = (word_idx == HDR_MODE_IDX) | (word_idx == HDR_MIN_IDX) |
                           (word_idx == HDR_SEC_IDX) | (word_idx == HDR_FRM_IDX) |
                           (word_idx == Q_TRACK_IDX) | (word_idx == Q_MODE_IDX) |
                           (word_idx == Q_AMIN_IDX) | (word_idx == Q_ASEC_IDX) |
                           (word_idx == Q_AFRM_IDX);
  wire        mapped     = sel_ctrl | sel_stat | sel_ro;
  wire        ctrl_write = access_ph & pwrite & sel_ctrl;
  wire        stat_read  = access_ph & ~pwrite & sel_stat;
  wire [7:0]  read_status_reg = {data_clock_run, q_crc_fail_flag_q, q_frame_ready_q,
                                 header_valid_flag_q, 4'h0};

  // read mux, sampled in setup so prdata comes from a flop with no wait state
  wire [7:0]  rd_byte    = (word_idx == HDR_MODE_IDX) ? hdr_mode_q :
                           (word_idx == HDR_MIN_IDX)  ? hdr_minute_reg_q :
                           (word_idx == HDR_SEC_IDX)  ? hdr_second_reg_q :
                           (word_idx == HDR_FRM_IDX)  ? hdr_frame_reg_q :
                           (word_idx == Q_TRACK_IDX)  ? q_track_reg_q :
                           (word_idx == Q_MODE_IDX)   ? q_mode_reg_q :
                           (word_idx == Q_AMIN_IDX)   ? q_abs_minute_reg_q :
                           (word_idx == Q_ASEC_IDX)   ? q_abs_second_reg_q :
                           (word_idx == Q_AFRM_IDX)   ? q_abs_frame_reg_q :
                           sel_ctrl                   ? front_ctrl_reg_q :
                           sel_stat                   ? read_status_reg :
                           8'h00;

  // bus answer registers
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_q <= ~mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = pslverr_q & access_ph;

  // resync falls; prev resets to the bit's reset level so reset gives no false edge
  wire resync_fall = resync_prev_q & ~resync_pulse;
  // front-end control register and the sync search a resync launches
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      front_ctrl_reg_q <= FRONT_CTRL_RESET;
      resync_prev_q    <= 1'b0;
      search_q         <= 1'b0;
    end
    else
    begin
      if (ctrl_write)
        front_ctrl_reg_q <= pwdata[7:0];
      resync_prev_q <= resync_pulse;
      if (resync_fall)
        search_q <= 1'b1;
      else if (sync_found)
        search_q <= 1'b0;
    end
  end

  wire q_done      = q_bit_valid & (q_cnt_q == 7'(Q_BITS - 1)) & ~frame_seq_reset;

  // data flow gate toward the buffer
  wire flow_start_d = sync_found & ~stop_command;
  wire flow_stop_d  = sync_found & stop_command;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      flow_q <= 1'b0;
    else if (frame_seq_reset)
      flow_q <= 1'b0;
    else if (audio_mode_select)
    begin
      if (f1_cflag)
        flow_q <= redbook_enable;
    end
    else if (!sync_async_select && stop_command)
      flow_q <= 1'b0;                                           // panic stop, mid-frame
    else if (flow_start_d)
      flow_q <= 1'b1;
    else if (flow_stop_d)
      flow_q <= 1'b0;
  end

  // header sequencer: four bytes after a sync that arrives while idle, in data mode
  wire hdr_go   = sync_found & ~audio_mode_select & ~frame_seq_reset;
  wire hdr_last = (hdr_state_q == HS_HEADER) & data_byte_valid & (hdr_cnt_q == HB_MODE);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hdr_state_q <= HS_IDLE;
      hdr_cnt_q   <= 2'h0;
    end
    else
    begin
      case (hdr_state_q)
        HS_IDLE:
          if (hdr_go)
            hdr_state_q <= HS_HEADER;
        HS_HEADER:
          if (frame_seq_reset || audio_mode_select)
            hdr_state_q <= HS_IDLE;
          else if (hdr_last)
            hdr_state_q <= HS_BODY;
        HS_BODY:
          if (sector_end || frame_seq_reset)
            hdr_state_q <= HS_IDLE;
        default:
          hdr_state_q <= HS_IDLE;
      endcase
      if (hdr_state_q != HS_HEADER)
        hdr_cnt_q <= 2'h0;
      else if (data_byte_valid)
        hdr_cnt_q <= hdr_cnt_q + 2'h1;
    end
  end

  // header flag: a capture in the same cycle as a clear wins
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      header_valid_flag_q <= 1'b0;
    else if (hdr_last)
      header_valid_flag_q <= 1'b1;
    else if (resync_fall || hdr_go || audio_mode_select)
      header_valid_flag_q <= 1'b0;
  end

  // header bytes; in audio mode the address follows the q channel
  wire hdr_take = (hdr_state_q == HS_HEADER) & data_byte_valid & ~frame_seq_reset;
  wire q_to_msf = q_done & audio_mode_select;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hdr_mode_q       <= 8'h00;
      hdr_minute_reg_q <= 8'h00;
      hdr_second_reg_q <= 8'h00;
      hdr_frame_reg_q  <= 8'h00;
    end
    else if (q_to_msf)
    begin
      hdr_minute_reg_q <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_AMIN-1 -: 8];
      hdr_second_reg_q <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_ASEC-1 -: 8];
      hdr_frame_reg_q  <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_AFRM-1 -: 8];
    end
    else if (hdr_take)
    begin
      case (hdr_cnt_q)
        HB_MIN:  hdr_minute_reg_q <= data_byte;
        HB_SEC:  hdr_second_reg_q <= data_byte;
        HB_FRM:  hdr_frame_reg_q  <= data_byte;
        HB_MODE: hdr_mode_q       <= data_byte;
        default: hdr_mode_q       <= hdr_mode_q;
      endcase
    end
  end

  // q frame assembly: crc over the first ten bytes, compare with inverted parity
  wire q_in_data = (q_cnt_q < 7'(Q_DATA_BITS));
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q_cnt_q      <= 7'h00;
      q_shift_q    <= '0;
      q_crc_q      <= Q_CRC_INIT;
      q_mismatch_q <= 1'b0;
    end
    else if (frame_seq_reset || q_frame_start)
    begin
      q_cnt_q      <= 7'h00;
      q_crc_q      <= Q_CRC_INIT;
      q_mismatch_q <= 1'b0;
    end
    else if (q_bit_valid)
    begin
      q_cnt_q <= q_done ? 7'h00 : q_cnt_q + 7'h01;
      if (q_in_data)
      begin
        q_shift_q <= {q_shift_q[Q_DATA_BITS-2:0], q_bit};
        q_crc_q   <= crc_step(q_crc_q, q_bit);
      end
      else
      begin
        q_crc_q      <= {q_crc_q[14:0], 1'b0};
        q_mismatch_q <= q_done ? 1'b0 : (q_mismatch_q | (q_bit == q_crc_q[15]));
      end
    end
  end

  // result includes the last parity bit, so it exists only at frame end
  wire q_fail_now = q_mismatch_q | (q_bit == q_crc_q[15]);

  // q registers load only on a completed frame
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q_track_reg_q      <= 8'h00;
      q_mode_reg_q       <= 8'h00;
      q_abs_minute_reg_q <= 8'h00;
      q_abs_second_reg_q <= 8'h00;
      q_abs_frame_reg_q  <= 8'h00;
    end
    else if (q_done)
    begin
      q_mode_reg_q       <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_MODE-1 -: 8];
      q_track_reg_q      <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_TRK-1 -: 8];
      q_abs_minute_reg_q <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_AMIN-1 -: 8];
      q_abs_second_reg_q <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_ASEC-1 -: 8];
      q_abs_frame_reg_q  <= q_shift_q[Q_DATA_BITS-8*Q_BYTE_AFRM-1 -: 8];
    end
  end

  // q status flags; a new frame beats a read clear or a sector end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q_frame_ready_q   <= 1'b0;
      q_crc_fail_flag_q <= 1'b1;
    end
    else
    begin
      if (q_done)
        q_frame_ready_q <= 1'b1;
      else if (stat_read)
        q_frame_ready_q <= 1'b0;
      if (q_done)
        q_crc_fail_flag_q <= q_fail_now;
      else if (sector_end && data_clock_run)
        q_crc_fail_flag_q <= 1'b1;
    end
  end

  // outputs driven from registered control state
  assign store_enable      = flow_q & ~frame_seq_reset;
  assign sync_search       = search_q;
  assign tx_break          = front_ctrl_reg_q[FC_TX_BREAK];
  assign watchdog_off      = watchdog_disable;
  assign seq_reset         = frame_seq_reset;
  assign audio_clock_shift = audio_mode_select;
endmodule : cd_header_subcode_capture

// >>> cd_capture_monitor.sv
// port-level assertions for the header and sub-code capture block
module cd_capture_monitor
  import capture_pkg::*;
(
  input wire logic [capture_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_found,
  input wire logic f1_cflag,
  input wire logic store_enable,
  input wire logic sync_search,
  input wire logic tx_break,
  input wire logic watchdog_off,
  input wire logic seq_reset,
  input wire logic audio_clock_shift
);
  logic [7:0] ctrl_q;
  wire        acc = psel && penable && pready;
  wire        ctrl_wr = acc && pwrite && paddr[17:2] == FRONT_CTRL_IDX;
  // shadow of the control byte; the block's own copy is not visible at the ports
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      ctrl_q <= FRONT_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_q <= pwdata[7:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_ctrl_bits;
    ctrl_wr |=> {seq_reset, tx_break, watchdog_off, audio_clock_shift} ==
      {$past(pwdata[7]), $past(pwdata[5]), $past(pwdata[4]), $past(pwdata[2])};
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control outputs wrong");
  property p_byte_wide;
    acc && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("read upper bits set");
  property p_ro_quiet;
    acc && (paddr[17:2] == HDR_MIN_IDX || paddr[17:2] == Q_TRACK_IDX) |-> !pslverr;
  endproperty
  a_ro_quiet: assert property (p_ro_quiet) else $error("error on capture register");
  property p_sync_start;
    sync_found && ctrl_q[1] && !ctrl_q[2] && !ctrl_q[7] |=> store_enable == !$past(ctrl_q[0]);
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("flow wrong at sync");
  property p_async_stop;
    ctrl_wr && pwdata[2:0] == 3'h1 |-> ##[1:2] !store_enable;
  endproperty
  a_async_stop: assert property (p_async_stop) else $error("flow not stopped");
  property p_f1_flow;
    f1_cflag && ctrl_q[2] && !ctrl_q[7] |=> store_enable == $past(ctrl_q[3]);
  endproperty
  a_f1_flow: assert property (p_f1_flow) else $error("flow wrong at f1 flag");
  property p_resync;
    ctrl_wr && ctrl_q[6] && !pwdata[6] |=> ##1 sync_search;
  endproperty
  a_resync: assert property (p_resync) else $error("sync search not started");
  property p_audio_shift;
    audio_clock_shift == ctrl_q[2];
  endproperty
  a_audio_shift: assert property (p_audio_shift) else $error("audio shift wrong");
endmodule : cd_capture_monitor

bind cd_header_subcode_capture cd_capture_monitor i_cd_capture_monitor (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_found(sync_found),
  .f1_cflag(f1_cflag), .store_enable(store_enable), .sync_search(sync_search), .tx_break(tx_break),
  .watchdog_off(watchdog_off), .seq_reset(seq_reset), .audio_clock_shift(audio_clock_shift));

// >>> cd_decoder_model.sv
// behavioural cd decoder: sector header bytes, q sub-code and event pulses
module cd_decoder_model
  import capture_pkg::*;
(
  input  wire logic  mclk,
  output logic [7:0] data_byte,
  output logic       data_byte_valid,
  output logic       sync_found,
  output logic       sector_end,
  output logic       f1_cflag,
  output logic       q_bit,
  output logic       q_bit_valid,
  output logic       q_frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // all strobes quiet until a task is called
  initial
  begin
    {data_byte, data_byte_valid, sync_found, sector_end} = 11'h0;
    {f1_cflag, q_bit, q_bit_valid, q_frame_start} = 4'h0;
  end
  // sync pulse then minute, second, frame, mode
  task automatic send_header(input logic [31:0] b);
    @(posedge mclk) sync_found <= 1'b1;
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge mclk);
      sync_found <= 1'b0;
      data_byte <= b[8*i +: 8];
      data_byte_valid <= 1'b1;
    end
    @(posedge mclk);
    data_byte_valid <= 1'b0;
    data_byte <= ~data_byte; // released bus must not show the last byte
  endtask : send_header
  // ten data bytes plus inverted crc, msb first; bad flips one parity bit
  task automatic send_q(input logic [79:0] d, input logic bad);
    logic [15:0] c;
    logic [95:0] f;
    c = Q_CRC_INIT;
    for (int i = 79; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? Q_CRC_POLY : 16'h0);
    f = {d, ~c ^ {15'h0, bad}};
    @(posedge mclk) q_frame_start <= 1'b1;
    @(posedge mclk) q_frame_start <= 1'b0;
    for (int i = 95; i >= 0; i--)
    begin
      q_bit <= f[i];
      q_bit_valid <= 1'b1;
      @(posedge mclk);
    end
    q_bit_valid <= 1'b0;
    q_bit <= ~f[0];
  endtask : send_q
  task automatic end_sector();
    @(posedge mclk) sector_end <= 1'b1;
    @(posedge mclk) sector_end <= 1'b0;
  endtask : end_sector
  task automatic f1_flag();
    @(posedge mclk) f1_cflag <= 1'b1;
    @(posedge mclk) f1_cflag <= 1'b0;
  endtask : f1_flag
endmodule : cd_decoder_model

// >>> test_cd_header_subcode_capture.sv
// self-checking bench for the header and sub-code capture block
module test_cd_header_subcode_capture;
  import capture_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [7:0]  data_byte;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        pready, pslverr, data_byte_valid, sync_found, sector_end, f1_cflag;
  logic        q_bit, q_bit_valid, q_frame_start, store_enable, sync_search;
  logic        tx_break, watchdog_off, seq_reset, audio_clock_shift;
  int          n_mismatch = 0;
  int          n_tests = 0;
  // firmware wait before sampling bad-q; shortened stand-in for the speed-dependent delay
  localparam int Q_CRC_FAIL_FLAG_WAIT = 8;
  cd_header_subcode_capture i_cd_header_subcode_capture (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_byte(data_byte),
    .data_byte_valid(data_byte_valid), .sync_found(sync_found), .sector_end(sector_end),
    .f1_cflag(f1_cflag), .q_bit(q_bit), .q_bit_valid(q_bit_valid), .q_frame_start(q_frame_start),
    .store_enable(store_enable), .sync_search(sync_search), .tx_break(tx_break),
    .watchdog_off(watchdog_off), .seq_reset(seq_reset), .audio_clock_shift(audio_clock_shift));
  cd_decoder_model i_cd_decoder_model (
    .mclk(mclk), .data_byte(data_byte), .data_byte_valid(data_byte_valid), .sync_found(sync_found),
    .sector_end(sector_end), .f1_cflag(f1_cflag), .q_bit(q_bit), .q_bit_valid(q_bit_valid),
    .q_frame_start(q_frame_start));
  // 40 MHz system clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      n_mismatch++;
      $display("ERROR apb pready expected 1 seen %b", pready);
      wrap_up();
    end
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, v, d, e);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 8'h0, d, e);
    check($sformatf("register %h", idx), exp, d);
  endtask : rdc
  task automatic t_reset();
    rdc(FRONT_CTRL_IDX, 32'h01);
    rdc(READ_STAT_IDX, 32'h40);
    rdc(HDR_MIN_IDX, 32'h0);
    check("store_enable", 1'b0, store_enable);
  endtask : t_reset
  task automatic t_ctrl();
    wr(FRONT_CTRL_IDX, 8'hb4);
    #1 check("ctrl outputs", 4'hf, {seq_reset, tx_break, watchdog_off, audio_clock_shift});
    rdc(FRONT_CTRL_IDX, 32'hb4);
    wr(FRONT_CTRL_IDX, 8'h01);
    #1 check("ctrl outputs", 4'h0, {seq_reset, tx_break, watchdog_off, audio_clock_shift});
  endtask : t_ctrl
  task automatic t_q();
    wr(FRONT_CTRL_IDX, 8'h02);
    i_cd_decoder_model.send_q({16'h0105, 40'h0, 24'h214365}, 1'b0);
    rdc(READ_STAT_IDX, 32'ha0);
    repeat (Q_CRC_FAIL_FLAG_WAIT) @(posedge mclk);
    rdc(READ_STAT_IDX, 32'h80);
    rdc(Q_MODE_IDX, 32'h01);
    rdc(Q_TRACK_IDX, 32'h05);
    rdc(Q_AMIN_IDX, 32'h21);
    rdc(Q_ASEC_IDX, 32'h43);
    rdc(Q_AFRM_IDX, 32'h65);
    i_cd_decoder_model.end_sector();
    rdc(READ_STAT_IDX, 32'hc0);
    i_cd_decoder_model.send_q({16'h0105, 64'h0}, 1'b1);
    rdc(READ_STAT_IDX, 32'he0);
    wr(FRONT_CTRL_IDX, 8'h03);
    i_cd_decoder_model.send_q({16'h0105, 64'h0}, 1'b0);
    i_cd_decoder_model.end_sector();
    rdc(READ_STAT_IDX, 32'h20);
  endtask : t_q
  task automatic t_header();
    logic [31:0] d;
    logic e;
    wr(FRONT_CTRL_IDX, 8'h02);
    i_cd_decoder_model.send_header(32'h12345602);
    #1 check("store_enable", 1'b1, store_enable);
    rdc(READ_STAT_IDX, 32'h90);
    rdc(HDR_MIN_IDX, 32'h12);
    rdc(HDR_SEC_IDX, 32'h34);
    rdc(HDR_FRM_IDX, 32'h56);
    rdc(HDR_MODE_IDX, 32'h02);
    wr(HDR_MIN_IDX, 8'hff);
    rdc(HDR_MIN_IDX, 32'h12);
    apb(1'b0, 16'hf000, 8'h0, d, e);
    check("unmapped error", 1'b1, e);
    check("unmapped data", 32'h0, d);
    wr(FRONT_CTRL_IDX, 8'h01);
    @(posedge mclk);
    #1 check("store_enable", 1'b0, store_enable);
    wr(FRONT_CTRL_IDX, 8'h42);
    wr(FRONT_CTRL_IDX, 8'h02);
    @(posedge mclk);
    #1 check("sync_search", 1'b1, sync_search);
    rdc(READ_STAT_IDX, 32'h80);
  endtask : t_header
  task automatic t_audio();
    wr(FRONT_CTRL_IDX, 8'h0e);
    i_cd_decoder_model.f1_flag();
    #1 check("store_enable", 1'b1, store_enable);
    i_cd_decoder_model.send_q({16'h0105, 40'h0, 24'h112233}, 1'b0);
    rdc(HDR_MIN_IDX, 32'h11);
    rdc(HDR_SEC_IDX, 32'h22);
    rdc(HDR_FRM_IDX, 32'h33);
    wr(FRONT_CTRL_IDX, 8'h06);
    i_cd_decoder_model.f1_flag();
    #1 check("store_enable", 1'b0, store_enable);
  endtask : t_audio
  // main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_ctrl();
    t_q();
    t_header();
    t_audio();
    wrap_up();
  end
endmodule : test_cd_header_subcode_capture
